// ### hdl/spi_burst_control.v
// burst control and transmit queue sequencing of an spi controller
// assumes one clock, sclk and select pins sampled through pin_sync
// What this block does
// - in slave mode, slave_select_control picks how a burst ends.
// - slave, control zero: burst ends after burst length field plus one bits.
// - slave, control one: burst ends when select input negates.
// - slave mode uses burst length only while slave_select_control is clear.
// - burst length field holds bit count minus one.
// - master bursts of 32n+1 bits take one more queue word and send only its first bit.
// - exchange_trigger starts a transfer of the queued data.
// - queue writes during exchange never disturb empty flag or read pointer.
// - with auto start clear, no duplicate send can arise.
`include "spi_burst_defs.vh"
module spi_burst_control (
    input wire mclk_in,
    input wire reset_in,
    input wire master_mode_in,
    input wire slave_select_control_in,
    input wire auto_start_on_fill_in,
    input wire exchange_trigger_in,
    input wire [`BURST_LEN_W-1:0] burst_length_in,
    input wire [`WORD_W-1:0] tx_data_in,
    input wire tx_write_in,
    input wire [7:0] sclk_half_div_in,
    input wire slave_sclk_in,
    input wire slave_select_input_in,
    input wire slave_mosi_in,
    output wire tx_ready_out,
    output reg sclk_out,
    output reg mosi_out,
    output reg select_n_out,
    output reg miso_out,
    output reg miso_oe_out,
    output reg busy_out,
    output reg burst_done_out,
    output reg tx_empty_out,
    output reg [`QUEUE_AW:0] tx_fifo_read_pointer_out,
    output reg [`WORD_W-1:0] rx_word_out,
    output reg rx_valid_out
);
    reg [`WORD_W-1:0] transmit_queue [0:`QUEUE_DEPTH-1];
    reg [`QUEUE_AW:0] wr_ptr;
    reg [`QUEUE_AW:0] rd_ptr;
    reg [1:0] state;
    reg [`BURST_LEN_W-1:0] bits_left;
    reg [`BIT_IDX_W-1:0] bit_idx;
    reg [`WORD_W-1:0] shift_tx;
    reg [`WORD_W-1:0] shift_rx;
    reg [7:0] div_cnt;
    reg sclk_q;
    reg sel_q;
    wire sclk_s;
    wire sel_s;
    wire mosi_s;
    wire last_bit;
    wire [`WORD_W-1:0] head_word;
    wire queue_empty;
    wire queue_full;
    wire tick;
    wire shift_edge;
    wire sample_edge;
    wire sel_negate;
    wire start;

    pin_sync u_sync_sclk (
        .mclk_in(mclk_in),
        .reset_in(reset_in),
        .pin_in(slave_sclk_in),
        .reset_level_in(1'b0),
        .level_out(sclk_s)
    );
    pin_sync u_sync_sel (
        .mclk_in(mclk_in),
        .reset_in(reset_in),
        .pin_in(slave_select_input_in),
        .reset_level_in(1'b1),
        .level_out(sel_s)
    );
    // data pin takes the same path as the clock pin, so both line up at the sample
    pin_sync u_sync_mosi (
        .mclk_in(mclk_in),
        .reset_in(reset_in),
        .pin_in(slave_mosi_in),
        .reset_level_in(1'b0),
        .level_out(mosi_s)
    );

    function [`QUEUE_AW:0] ptr_inc;
        input [`QUEUE_AW:0] p;
        begin
            ptr_inc = p + 1'b1;
        end
    endfunction

    // empty derives from registered pointers only, so a write mid-burst cannot glitch it
    assign queue_empty = (wr_ptr == rd_ptr);
    assign head_word = transmit_queue[rd_ptr[`QUEUE_AW-1:0]];
    // counting ends master bursts, and slave bursts when control bit clear
    assign last_bit = (master_mode_in || !slave_select_control_in)
        && (bits_left == {`BURST_LEN_W{1'b0}});
    assign queue_full = (wr_ptr[`QUEUE_AW-1:0] == rd_ptr[`QUEUE_AW-1:0])
        && (wr_ptr[`QUEUE_AW] != rd_ptr[`QUEUE_AW]);
    assign tx_ready_out = !queue_full;
    assign tick = master_mode_in && (div_cnt == 8'h00);
    // master: drive on falling sclk, sample on rising; slave: same edges of the pin
    assign shift_edge = master_mode_in ? (tick && sclk_q) : (sclk_q && !sclk_s);
    assign sample_edge = master_mode_in ? (tick && !sclk_q) : (!sclk_q && sclk_s);
    assign sel_negate = !sel_q && sel_s;
    // trigger or, with auto start, any queued data starts the burst
    assign start = (state == `ST_IDLE) && !queue_empty
        && (exchange_trigger_in || auto_start_on_fill_in);

    always @(posedge mclk_in)
    begin
        if (reset_in)
        begin
            wr_ptr <= {(`QUEUE_AW+1){1'b0}};
        end
        else if (tx_write_in && !queue_full)
        begin
            // only the write pointer moves; the read side is untouched
            transmit_queue[wr_ptr[`QUEUE_AW-1:0]] <= tx_data_in;
            wr_ptr <= ptr_inc(wr_ptr);
        end
    end

    always @(posedge mclk_in)
    begin
        if (reset_in)
        begin
            state <= `ST_IDLE;
            rd_ptr <= {(`QUEUE_AW+1){1'b0}};
            bits_left <= {`BURST_LEN_W{1'b0}};
            bit_idx <= {`BIT_IDX_W{1'b0}};
            shift_tx <= {`WORD_W{1'b0}};
            shift_rx <= {`WORD_W{1'b0}};
            div_cnt <= 8'h00;
            sclk_q <= 1'b0;
            sel_q <= 1'b1;
            sclk_out <= 1'b0;
            mosi_out <= 1'b0;
            select_n_out <= 1'b1;
            miso_out <= 1'b0;
            miso_oe_out <= 1'b0;
            busy_out <= 1'b0;
            burst_done_out <= 1'b0;
            tx_empty_out <= 1'b1;
            tx_fifo_read_pointer_out <= {(`QUEUE_AW+1){1'b0}};
            rx_word_out <= {`WORD_W{1'b0}};
            rx_valid_out <= 1'b0;
        end
        else
        begin
            burst_done_out <= 1'b0;
            rx_valid_out <= 1'b0;
            tx_empty_out <= queue_empty;
            tx_fifo_read_pointer_out <= rd_ptr;
            if (master_mode_in)
                sclk_q <= tick ? !sclk_q : sclk_q;
            else
                sclk_q <= sclk_s;
            sel_q <= sel_s;
            div_cnt <= (!master_mode_in || tick) ? sclk_half_div_in : div_cnt - 8'h01;
            case (state)
                `ST_IDLE:
                begin
                    sclk_q <= 1'b0;
                    sclk_out <= 1'b0;
                    if (start)
                    begin
                        // field is count minus one; the field loads as is
                        bits_left <= burst_length_in;
                        // the word leaves the queue once, pointer steps once per word
                        // first bit goes out now, ahead of the first rising clock
                        mosi_out <= head_word[`WORD_W-1];
                        miso_out <= head_word[`WORD_W-1];
                        shift_tx <= {head_word[`WORD_W-2:0], 1'b0};
                        rd_ptr <= ptr_inc(rd_ptr);
                        bit_idx <= {`BIT_IDX_W{1'b0}};
                        busy_out <= 1'b1;
                        select_n_out <= !master_mode_in;
                        miso_oe_out <= !master_mode_in;
                        state <= `ST_RUN;
                    end
                end
                `ST_RUN:
                begin
                    if (master_mode_in)
                        sclk_out <= tick ? !sclk_q : sclk_q;
                    if (shift_edge)
                    begin
                        mosi_out <= shift_tx[`WORD_W-1];
                        miso_out <= shift_tx[`WORD_W-1];
                        shift_tx <= {shift_tx[`WORD_W-2:0], 1'b0};
                    end
                    if (sample_edge)
                    begin
                        shift_rx <= {shift_rx[`WORD_W-2:0], master_mode_in ? 1'b0 : mosi_s};
                        bit_idx <= bit_idx + 1'b1;
                        if (bit_idx == {`BIT_IDX_W{1'b1}})
                        begin
                            rx_word_out <= {shift_rx[`WORD_W-2:0], mosi_s};
                            rx_valid_out <= 1'b1;
                            // next word only at a boundary inside the burst; the last bit
                            // must not swallow a word that will never be sent
                            if (!queue_empty && !last_bit)
                            begin
                                shift_tx <= head_word;
                                rd_ptr <= ptr_inc(rd_ptr);
                            end
                        end
                        if (last_bit)
                            state <= `ST_DONE;
                        else
                            bits_left <= bits_left - 1'b1;
                    end
                    // select negation ends a slave burst when the control bit is set
                    if (!master_mode_in && slave_select_control_in && sel_negate)
                        state <= `ST_DONE;
                end
                `ST_DONE:
                begin
                    if (bit_idx != {`BIT_IDX_W{1'b0}})
                    begin
                        rx_word_out <= shift_rx;
                        rx_valid_out <= 1'b1;
                    end
                    busy_out <= 1'b0;
                    burst_done_out <= 1'b1;
                    select_n_out <= 1'b1;
                    miso_oe_out <= 1'b0;
                    sclk_out <= 1'b0;
                    state <= `ST_IDLE;
                end
                default:
                    state <= `ST_IDLE;
            endcase
        end
    end
endmodule

// ### hdl/spi_burst_defs.vh
// constants for the spi burst controller: field widths, states, queue depth
// assumes inclusion by bare name from the design files
`ifndef SPI_BURST_DEFS_VH
`define SPI_BURST_DEFS_VH
`define BURST_LEN_W 12
`define WORD_W 32
`define QUEUE_AW 3
`define QUEUE_DEPTH 8
`define BIT_IDX_W 5
`define ST_IDLE 2'h0
`define ST_RUN 2'h1
`define ST_DONE 2'h2
`endif

// ### hdl/pin_sync.v
// three-stage synchroniser for one pin input with second/third agreement
// assumes the pin is asynchronous to mclk_in
`include "spi_burst_defs.vh"
module pin_sync (
    input wire mclk_in,
    input wire reset_in,
    input wire pin_in,
    input wire reset_level_in,
    output reg level_out
);
    reg s1;
    reg s2;
    reg s3;
    always @(posedge mclk_in)
    begin
        if (reset_in)
        begin
            // each pin rests at its own idle level, so no false edge follows reset
            s1 <= reset_level_in;
            s2 <= reset_level_in;
            s3 <= reset_level_in;
            level_out <= reset_level_in;
        end
        else
        begin
            s1 <= pin_in;
            s2 <= s1;
            s3 <= s2;
            // a change counts only once the last two stages agree
            if (s2 == s3)
                level_out <= s3;
        end
    end
endmodule

// ### sim/spi_burst_checker.sv
// port assertions for spi_burst_control: burst start, end and pin rest levels
// assumes one clock, synchronous active-high reset, bound onto the design
module spi_burst_checker (
    input wire logic mclk_in,
    input wire logic reset_in,
    input wire logic master_mode_in,
    input wire logic auto_start_on_fill_in,
    input wire logic exchange_trigger_in,
    input wire logic busy_out,
    input wire logic burst_done_out,
    input wire logic select_n_out,
    input wire logic sclk_out,
    input wire logic miso_oe_out,
    input wire logic tx_empty_out
);
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (reset_in);
    chk_done_single:
        assert property (burst_done_out |=> !burst_done_out)
        else $error("done pulse longer than one cycle");
    chk_done_idles:
        assert property (burst_done_out |-> !busy_out)
        else $error("busy still high after done");
    chk_busy_ends_done:
        assert property ($fell(busy_out) |-> burst_done_out || $past(burst_done_out))
        else $error("burst ended without done pulse");
    // empty flag lags one cycle, so two idle cycles are required first
    chk_trigger_start:
        assert property (master_mode_in && !busy_out && !$past(busy_out) && !tx_empty_out
            && exchange_trigger_in |=> busy_out)
        else $error("trigger on filled queue did not start");
    chk_auto_start:
        assert property (master_mode_in && !busy_out && !$past(busy_out) && !tx_empty_out
            && auto_start_on_fill_in |=> busy_out)
        else $error("auto start did not begin a burst");
    chk_no_self_start:
        assert property (master_mode_in && !busy_out && !burst_done_out
            && !exchange_trigger_in && !auto_start_on_fill_in |=> !busy_out)
        else $error("burst began without a start request");
    chk_sclk_rest:
        assert property (select_n_out |-> !sclk_out)
        else $error("clock high while deselected");
    chk_oe_slave_only:
        assert property (miso_oe_out |-> !master_mode_in)
        else $error("slave output driven in master mode");
endmodule
bind spi_burst_control spi_burst_checker i_chk (.mclk_in, .reset_in, .master_mode_in,
    .auto_start_on_fill_in, .exchange_trigger_in, .busy_out, .burst_done_out,
    .select_n_out, .sclk_out, .miso_oe_out, .tx_empty_out);

// ### sim/spi_far_end.sv
// far-side spi device: records master bursts, drives slave bursts
// assumes mode 0: data moves while the clock is low, sampled on its rise
module spi_far_end (
    input wire logic sclk_in,
    input wire logic select_n_in,
    input wire logic mosi_in,
    output logic far_sclk_out,
    output logic far_select_n_out,
    output logic far_mosi_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic got[$];
    initial
    begin
        far_sclk_out = 1'b0;
        far_select_n_out = 1'b1;
        far_mosi_out = 1'b0;
    end
    always @(posedge sclk_in)
        if (!select_n_in)
            got.push_back(mosi_in);
    task automatic send(input int n, input logic [31:0] d, input int half);
        far_select_n_out = 1'b0;
        for (int i = n - 1; i >= 0; i--)
        begin
            far_mosi_out = d[i];
            #(half) far_sclk_out = 1'b1;
            #(half) far_sclk_out = 1'b0;
        end
        #(half) far_select_n_out = 1'b1;
        // released line must not keep showing the last bit
        far_mosi_out = ~far_mosi_out;
    endtask
endmodule

// ### sim/spi_burst_control_tb_top.sv
// self-checking bench: master and auto start bursts against a queue model, slave bursts against the word the far end drives
// assumes spi_far_end on the pins and the checker bound to the design
module spi_burst_control_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk_in = 1'b0;
    logic reset_in = 1'b1;
    logic master_mode_in = 1'b1;
    logic slave_select_control_in = 1'b0;
    logic auto_start_on_fill_in = 1'b0;
    logic exchange_trigger_in = 1'b0;
    logic tx_write_in = 1'b0;
    logic [11:0] burst_length_in = 12'h000;
    logic [31:0] tx_data_in = 32'h00000000;
    logic [7:0] sclk_half_div_in = 8'h00;
    wire tx_ready_out, sclk_out, mosi_out, select_n_out, miso_oe_out, busy_out;
    wire burst_done_out, tx_empty_out, far_sclk, far_sel_n, far_mosi;
    wire [31:0] rx_word_out;
    wire [3:0] rd_seen;
    logic [31:0] mask;
    logic [31:0] mq[$];
    logic [31:0] d;
    int bad_count = 0;
    int checked = 0;
    int rnd;
    int n;
    spi_burst_control i_dut (.mclk_in, .reset_in, .master_mode_in, .slave_select_control_in,
        .auto_start_on_fill_in, .exchange_trigger_in, .burst_length_in, .tx_data_in,
        .tx_write_in, .sclk_half_div_in, .slave_sclk_in(far_sclk),
        .slave_select_input_in(far_sel_n), .slave_mosi_in(far_mosi), .tx_ready_out, .sclk_out,
        .mosi_out, .select_n_out, .miso_out(), .miso_oe_out, .busy_out, .burst_done_out,
        .tx_empty_out, .tx_fifo_read_pointer_out(rd_seen), .rx_word_out, .rx_valid_out());
    spi_far_end far (.sclk_in(sclk_out), .select_n_in(select_n_out), .mosi_in(mosi_out),
        .far_sclk_out(far_sclk), .far_select_n_out(far_sel_n), .far_mosi_out(far_mosi));
    initial
    begin
        forever #10 mclk_in = ~mclk_in;
    end
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            bad_count++;
            $display("wrong value %0s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic push(input logic [31:0] w);
        @(posedge mclk_in);
        tx_data_in <= w;
        tx_write_in <= 1'b1;
        mq.push_back(w);
        @(posedge mclk_in);
        tx_write_in <= 1'b0;
    endtask
    task automatic start(input logic [11:0] len);
        @(posedge mclk_in);
        burst_length_in <= len;
        exchange_trigger_in <= 1'b1;
        @(posedge mclk_in);
        exchange_trigger_in <= 1'b0;
    endtask
    task automatic wait_done();
        int k;
        for (k = 0; k < 20000; k++)
        begin
            @(negedge mclk_in);
            if (burst_done_out === 1'b1)
                break;
        end
        if (k == 20000)
        begin
            bad_count++;
            report_and_stop();
        end
    endtask
    task automatic check_burst(input int bits, input int words);
        logic [31:0] seen;
        check("bit count", bits, far.got.size());
        for (int j = 0; j < words; j++)
        begin
            for (int b = 0; b < 32; b++)
                seen[31 - b] = far.got[32 * j + b];
            check("sent word", mq.pop_front(), seen);
        end
        far.got.delete();
    endtask
    initial
    begin
        rnd = $urandom(71848);
        repeat (3) @(posedge mclk_in);
        reset_in <= 1'b0;
        sclk_half_div_in <= 8'($urandom_range(3));
        start(12'h01F);
        repeat (4) @(negedge mclk_in);
        check("busy on empty queue", 32'h0, busy_out);
        push($urandom);
        push($urandom);
        start(12'h03F);
        fork
            wait_done();
            begin
                repeat (20) @(posedge mclk_in);
                push($urandom);
            end
        join
        check_burst(64, 2);
        repeat (2) @(negedge mclk_in);
        check("empty after write", 32'h0, tx_empty_out);
        check("read pointer", 32'h2, rd_seen);
        start(12'h01F);
        wait_done();
        check_burst(32, 1);
        repeat (2) @(negedge mclk_in);
        check("empty when drained", 32'h1, tx_empty_out);
        check("read pointer", 32'h3, rd_seen);
        $display("test master bursts finished");
        @(posedge mclk_in);
        auto_start_on_fill_in <= 1'b1;
        push($urandom);
        wait_done();
        @(posedge mclk_in);
        auto_start_on_fill_in <= 1'b0;
        check_burst(32, 1);
        push($urandom);
        push($urandom);
        start(12'h020);
        wait_done();
        check_burst(33, 1);
        mq.delete();
        $display("test auto start and odd length finished");
        @(posedge mclk_in);
        master_mode_in <= 1'b0;
        for (int m = 0; m < 2; m++)
        begin
            @(posedge mclk_in);
            slave_select_control_in <= (m == 1);
            n = 8 - 3 * m;
            d = $urandom;
            push($urandom);
            mask = (32'h1 << n) - 32'h1;
            start(m == 1 ? 12'h01F : 12'h007);
            fork
                far.send(n, d, 100);
                wait_done();
            join
            check("slave word", d & mask, rx_word_out & mask);
        end
        $display("test slave bursts finished");
        report_and_stop();
    end
endmodule
